// ===== jdd_consts.svh
// constants and timing counts for the jack detect debounce block
// How it works
// R1: comparators enabled only while the jack detect enable bit is set
// R2: detection disabled: sense pin high impedance, whole interface shut down
// R3: shut down with detection disabled: status flags hold last values
// R4: load-sense comparator trips at 95 percent; debounced into load-sense flag
// R5: jack-type comparator trips at 10 percent; debounced into jack-type flag
// R6: flags 11 no jack, 01 headset, 00 headphones, 10 reserved
// R7: reference is speaker supply when shut down or mic bias off, else mic bias
// R8: internal pullup on when shut down or mic bias off, else pin high impedance
// R9: weak select low gives strong resistive pullup, high gives weak current pullup
// R10: a flag updates only after new comparator state persists past the timeout
// R11: debounce timeout has four settings from 25 ms to 200 ms
// R12: select 00 25 ms, 01 50 ms, 10 100 ms, 11 200 ms; resets to 00
// R13: any change of a debounced flag sets the jack change event flag
// R14: unmasked event flag drives the interrupt output; code sets irq only if unmasked as the event rises
// R15: host read of the event flag clears it and its interrupt
// R16: until read, flag and interrupt stay set and further events are ignored
// R17: host reads the event flag after every event
// R18: host reads load-sense fall as insertion, rise as removal; jack-type gives kind
// R19: debounce counts a millisecond tick, restarting when a comparator changes
`ifndef JDD_CONSTS_SVH
`define JDD_CONSTS_SVH
`define JDD_CLK_HZ        40000000
`define JDD_TICK_MS       1
`define JDD_TICK_CYCLES   ((`JDD_CLK_HZ / 1000) * `JDD_TICK_MS)
`define JDD_DEB_25_MS     25
`define JDD_DEB_50_MS     50
`define JDD_DEB_100_MS    100
`define JDD_DEB_200_MS    200
`define JDD_DEB_SEL_RST   2'h0
`define JDD_FLAG_RST      1'h0
`endif

// ===== jdd_jack_detect.sv
// jack insertion detect, debounce and change event logic
`timescale 1ns/1ps
`include "jdd_consts.svh"
module jdd_jack_detect #(
  parameter int TICK_CYCLES = `JDD_TICK_CYCLES
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  jack_detect_enable_bit_in,
  input  wire logic                  weak_pullup_select_in,
  input  wire jdd_pkg::jdd_deb_sel_t debounce_time_select_in,
  input  wire logic                  active_low_shutdown_in,
  input  wire logic                  mic_bias_enable_bit_in,
  input  wire logic                  jack_change_event_mask_in,
  input  wire logic                  event_read_in,
  input  wire logic                  load_cmp_raw_in,
  input  wire logic                  type_cmp_raw_in,
  output logic                       comparator_enable_out,
  output jdd_pkg::jdd_ref_t          reference_select_out,
  output logic                       strong_pullup_enable_out,
  output logic                       weak_pullup_enable_out,
  output logic                       load_sense_flag_out,
  output logic                       jack_type_flag_out,
  output logic                       jack_change_event_flag_out,
  output logic                       irq_out
);
  import jdd_pkg::*;

  // refused at elaboration, before any clock runs
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least 1");
  end
  // the millisecond counters are eight bits and saturate, so the longest limit must stay below that
  if (`JDD_DEB_200_MS > 254) begin : g_limit_check
    $error("debounce limit exceeds the millisecond counter");
  end

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // comparator outputs are asynchronous to the core clock
  logic load_s1_q;
  logic load_s2_q;
  logic type_s1_q;
  logic type_s2_q;
  logic [TW-1:0] tick_cnt_q;
  logic          tick_q;
  logic [7:0]    load_ms_q;
  logic [7:0]    type_ms_q;
  logic          load_last_q;
  logic          type_last_q;
  logic          load_flag_q;
  logic          type_flag_q;
  logic          event_q;
  logic          irq_q;
  logic          cmp_en_q;
  jdd_ref_t      ref_q;
  logic          strong_q;
  logic          weak_q;

  wire           det_en      = jack_detect_enable_bit_in;
  wire           dev_active  = active_low_shutdown_in;
  wire           use_mic_bias_output = dev_active & mic_bias_enable_bit_in;
  wire           pullup_on   = det_en & ~use_mic_bias_output;
  wire [7:0]     deb_limit   = (debounce_time_select_in == 2'h0) ? 8'(`JDD_DEB_25_MS) :
                               (debounce_time_select_in == 2'h1) ? 8'(`JDD_DEB_50_MS) :
                               (debounce_time_select_in == 2'h2) ? 8'(`JDD_DEB_100_MS) :
                                                                   8'(`JDD_DEB_200_MS); // R11 R12
  // a candidate must differ from the flag and be stable past the limit
  wire           load_moved  = load_s2_q != load_last_q;
  wire           type_moved  = type_s2_q != type_last_q;
  wire           load_done   = det_en & ~load_moved & (load_s2_q != load_flag_q) & (load_ms_q > deb_limit); // R10
  wire           type_done   = det_en & ~type_moved & (type_s2_q != type_flag_q) & (type_ms_q > deb_limit); // R10
  wire           any_change  = load_done | type_done;
  wire           tick_wrap   = tick_cnt_q == TW'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk_in) begin
    load_s1_q <= load_cmp_raw_in;
    load_s2_q <= load_s1_q;
    type_s1_q <= type_cmp_raw_in;
    type_s2_q <= type_s1_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !det_en) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1); // R19
      tick_q     <= tick_wrap;
    end
  end

  // each millisecond counter restarts when its own comparator moves
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      load_ms_q   <= '0;
      type_ms_q   <= '0;
      load_last_q <= 1'b0;
      type_last_q <= 1'b0;
    end else begin
      load_last_q <= load_s2_q;
      type_last_q <= type_s2_q;
      if (!det_en || load_moved || load_s2_q == load_flag_q)
        load_ms_q <= '0; // R19
      else if (tick_q && load_ms_q != 8'hFF)
        load_ms_q <= load_ms_q + 8'h01;
      if (!det_en || type_moved || type_s2_q == type_flag_q)
        type_ms_q <= '0; // R19
      else if (tick_q && type_ms_q != 8'hFF)
        type_ms_q <= type_ms_q + 8'h01;
    end
  end

  // flags hold while detection is off, so last result survives shutdown
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      load_flag_q <= `JDD_FLAG_RST;
      type_flag_q <= `JDD_FLAG_RST;
    end else begin
      if (load_done)
        load_flag_q <= load_s2_q; // R4 R3
      if (type_done)
        type_flag_q <= type_s2_q; // R5 R3 R6
    end
  end

  // read clears; a change while still set is dropped, not queued
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      event_q <= 1'b0;
      irq_q   <= 1'b0;
    end else if (event_read_in) begin
      event_q <= 1'b0; // R15
      irq_q   <= 1'b0; // R15
    end else if (!event_q && any_change) begin
      event_q <= 1'b1; // R13 R16
      irq_q   <= ~jack_change_event_mask_in; // R14
    end else begin
      irq_q   <= event_q & ~jack_change_event_mask_in & irq_q; // R16
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cmp_en_q <= 1'b0;
      ref_q    <= JDD_REF_SPK;
      strong_q <= 1'b0;
      weak_q   <= 1'b0;
    end else begin
      cmp_en_q <= det_en; // R1 R2
      ref_q    <= use_mic_bias_output ? JDD_REF_MICB : JDD_REF_SPK; // R7
      strong_q <= pullup_on & ~weak_pullup_select_in; // R8 R9 R2
      weak_q   <= pullup_on & weak_pullup_select_in; // R8 R9 R2
    end
  end

  assign comparator_enable_out      = cmp_en_q;
  assign reference_select_out       = ref_q;
  assign strong_pullup_enable_out   = strong_q;
  assign weak_pullup_enable_out     = weak_q;
  assign load_sense_flag_out        = load_flag_q;
  assign jack_type_flag_out         = type_flag_q;
  assign jack_change_event_flag_out = event_q;
  assign irq_out                    = irq_q;

  // assertions
  sequence s_flag_moved;
    $changed(load_flag_q) || $changed(type_flag_q);
  endsequence

  a_event_on_change: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R13
    s_flag_moved ##0 (!$past(event_q) && !$past(event_read_in)) |-> event_q)
    else $error("flag change did not raise event");

  a_read_clears: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R15
    event_read_in |=> !event_q && !irq_q)
    else $error("read did not clear event");

  a_event_holds: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R16
    event_q && !event_read_in |=> event_q)
    else $error("event dropped without read");

  a_irq_masked: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R14
    irq_q |-> event_q && !$past(jack_change_event_mask_in))
    else $error("interrupt without unmasked event");

  a_hold_disabled: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R3
    !det_en |=> $stable(load_flag_q) && $stable(type_flag_q))
    else $error("flags moved while detection off");

  a_cmp_enable: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R1
    ##1 comparator_enable_out == $past(det_en))
    else $error("comparator enable wrong");

  a_pullup_rule: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R8
    ##1 (strong_q || weak_q) == $past(pullup_on) && !(strong_q && weak_q))
    else $error("pullup select wrong");

  a_weak_select: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R9
    weak_q |-> $past(weak_pullup_select_in))
    else $error("weak pullup without select");

  a_reference: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R7
    ##1 (ref_q == JDD_REF_MICB) == $past(use_mic_bias_output))
    else $error("reference select wrong");

  a_debounce_min: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R10
    $changed(load_flag_q) |-> $past(load_ms_q) > $past(deb_limit))
    else $error("flag updated before debounce");

  a_type_debounce: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R10
    $changed(type_flag_q) |-> $past(type_ms_q) > $past(deb_limit))
    else $error("type flag updated before debounce");

  a_load_quiet: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R10
    !load_done |=> $stable(load_flag_q))
    else $error("load flag moved without debounce");

  a_type_quiet: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R10
    !type_done |=> $stable(type_flag_q))
    else $error("type flag moved without debounce");

  // event steps: a rise, and a rise while the interrupt is not masked
  sequence s_event_rise;
    !$past(event_q) && event_q;
  endsequence

  sequence s_unmasked_rise;
    s_event_rise ##0 !$past(jack_change_event_mask_in);
  endsequence

  a_irq_on_event: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R14
    s_unmasked_rise |-> irq_q)
    else $error("unmasked event without interrupt");

  a_mask_drops_irq: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R14
    jack_change_event_mask_in |=> !irq_q)
    else $error("interrupt while masked");

  a_event_cause: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R13
    s_event_rise |-> s_flag_moved)
    else $error("event without flag change");

  a_event_idle: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R13
    !event_q && !load_done && !type_done |=> !event_q)
    else $error("event raised with no change");

  a_no_new_irq: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R16
    event_q && !irq_q && !event_read_in |=> !irq_q)
    else $error("interrupt raised while event unread");

  a_irq_holds: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R16
    irq_q && !event_read_in && !jack_change_event_mask_in |=> irq_q)
    else $error("interrupt dropped without read");

  a_load_value: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R4
    $changed(load_flag_q) |-> load_flag_q == $past(load_s2_q))
    else $error("load flag not the comparator level");

  a_type_value: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R5
    $changed(type_flag_q) |-> type_flag_q == $past(type_s2_q))
    else $error("type flag not the comparator level");

  a_load_restart: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R19
    load_moved |=> load_ms_q == 8'h00)
    else $error("load count kept after movement");

  a_type_restart: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R19
    type_moved |=> type_ms_q == 8'h00)
    else $error("type count kept after movement");

  a_load_step: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R19
    load_ms_q > $past(load_ms_q) |-> $past(tick_q) && (load_ms_q == $past(load_ms_q) + 8'h01))
    else $error("load count stepped without tick");

  a_type_step: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R19
    type_ms_q > $past(type_ms_q) |-> $past(tick_q) && (type_ms_q == $past(type_ms_q) + 8'h01))
    else $error("type count stepped without tick");

  a_tick_gap: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R19
    (TICK_CYCLES > 1) && tick_q |=> !tick_q)
    else $error("tick wider than one cycle");

  a_tick_off: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R2
    !det_en |=> !tick_q && (tick_cnt_q == TW'(0)))
    else $error("tick running while detection off");

  a_disabled_quiet: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R2
    !det_en |=> !cmp_en_q && !strong_q && !weak_q)
    else $error("detection interface active while off");

  a_limit_decode: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R12
    deb_limit == (8'(`JDD_DEB_25_MS) << debounce_time_select_in))
    else $error("debounce limit decode wrong");

  a_ref_shutdown: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R7
    !dev_active |=> ref_q == JDD_REF_SPK)
    else $error("mic bias reference while shut down");

  a_pullup_shutdown: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R8
    det_en && !dev_active |=> strong_q || weak_q)
    else $error("no pullup while shut down");

  a_pullup_mic_bias_output: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R8
    use_mic_bias_output |=> !strong_q && !weak_q)
    else $error("pullup on with mic bias active");

  a_strong_default: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // R9
    det_en && !use_mic_bias_output && !weak_pullup_select_in |=> strong_q && !weak_q)
    else $error("strong pullup not selected");
endmodule

// ===== jdd_pkg.sv
// types for the jack detect debounce block
package jdd_pkg;
  typedef logic [1:0] jdd_deb_sel_t;
  typedef enum logic {
    JDD_REF_SPK,
    JDD_REF_MICB
  } jdd_ref_t;
endpackage

// ===== jdd_plug_model.sv
// behavioural plug in the audio jack, giving both comparator outputs
`timescale 1ns/1ps
module jdd_plug_model (
  input  wire logic       clk_in,
  input  wire logic       comp_en_in,
  input  wire logic       weak_in,
  input  wire logic [1:0] plug_in,
  output logic            load_cmp_out,
  output logic            type_cmp_out
);
  logic junk_q = 1'b0;
  // comparators off give no valid level, so show a changing pattern
  always_ff @(posedge clk_in) junk_q <= ~junk_q;
  // plug 0 open, 1 three-pole short, 2 four-pole mic
  // the weak pullup cannot bias a mic, so a headset then reads as headphones
  assign load_cmp_out = comp_en_in ? (plug_in == 2'h0) : junk_q;
  assign type_cmp_out = comp_en_in ? (plug_in == 2'h0 || (plug_in == 2'h2 && !weak_in)) : ~junk_q;
endmodule

// ===== testbench.sv
// self-checking bench for the jack detect debounce block
`timescale 1ns/1ps
module testbench;
  import jdd_pkg::*;
  localparam int TK = 4;
  logic         clk = 0, rst = 1, en = 0, wk = 0, active_low_shutdown_n = 1, mb = 0, msk = 0, rd = 0;
  jdd_deb_sel_t sel = 2'h0;
  logic [1:0]   plug = 2'h0;
  logic         lc, tc, cen, spu, wpu, ls, jt, ev, irq;
  jdd_ref_t     rsel;
  int           n_errors = 0;
  int           compares = 0;
  jdd_jack_detect #(.TICK_CYCLES(TK)) dut (.core_clk_in(clk), .sys_rst_in(rst),
    .jack_detect_enable_bit_in(en), .weak_pullup_select_in(wk), .debounce_time_select_in(sel),
    .active_low_shutdown_in(active_low_shutdown_n), .mic_bias_enable_bit_in(mb), .jack_change_event_mask_in(msk),
    .event_read_in(rd), .load_cmp_raw_in(lc), .type_cmp_raw_in(tc), .comparator_enable_out(cen),
    .reference_select_out(rsel), .strong_pullup_enable_out(spu), .weak_pullup_enable_out(wpu),
    .load_sense_flag_out(ls), .jack_type_flag_out(jt), .jack_change_event_flag_out(ev), .irq_out(irq));
  jdd_plug_model plug_i (.clk_in(clk), .comp_en_in(cen), .weak_in(wpu), .plug_in(plug),
    .load_cmp_out(lc), .type_cmp_out(tc));
  initial forever #12.5 clk = ~clk;
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one-cycle host read of the event flag
  task automatic read_ev;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
  endtask
  task automatic t_config;
    logic pu;
    for (int i = 0; i < 16; i++) begin
      {en, wk, active_low_shutdown_n, mb} = i[3:0];
      repeat (2) @(negedge clk);
      pu = en & (!active_low_shutdown_n | !mb);
      chk("comparator_enable", 8'(en), 8'(cen));
      chk("pullups", 8'({pu & !wk, pu & wk}), 8'({spu, wpu}));
      chk("reference_select", 8'(active_low_shutdown_n & mb), 8'(rsel));
    end
    // one edge with detection off clears any count started above
    {en, wk, active_low_shutdown_n, mb} = 4'h2;
    @(negedge clk);
  endtask
  // change the plug, see nothing before the timeout, then the new flags and event
  task automatic t_deb(logic [1:0] s, logic [1:0] p, logic [1:0] ej);
    logic [1:0] old;
    int         k;
    old = {ls, jt};
    en = 1'b1;
    sel = s;
    plug = p;
    repeat (((25 << s) - 1) * TK) @(negedge clk);
    chk("flags before timeout", 8'(old), 8'({ls, jt}));
    k = 0;
    while (ev !== 1'b1 && k < 6 * TK + 10) begin
      @(negedge clk);
      k++;
    end
    chk("flags", 8'(ej), 8'({ls, jt}));
    chk("event and irq", 8'({1'b1, !msk}), 8'({ev, irq}));
    read_ev();
    chk("event cleared", 8'h0, 8'({ev, irq}));
  endtask
  // a second change before the read is not signalled again
  task automatic t_sticky;
    plug = 2'h0;
    repeat (30 * TK) @(negedge clk);
    plug = 2'h1;
    repeat (30 * TK) @(negedge clk);
    chk("flags while unread", 8'h0, 8'({ls, jt}));
    chk("event held", 8'h3, 8'({ev, irq}));
    read_ev();
    repeat (10) @(negedge clk);
    chk("no event after read", 8'h0, 8'({ev, irq}));
  endtask
  // 20 ms open, a brief short, 20 ms open again: the count restarts
  task automatic t_glitch;
    plug = 2'h0;
    repeat (20 * TK) @(negedge clk);
    plug = 2'h1;
    repeat (5) @(negedge clk);
    plug = 2'h0;
    repeat (20 * TK) @(negedge clk);
    chk("flags after glitch", 8'h0, 8'({ls, jt, ev}));
  endtask
  // flags settle to open, then detection goes off and the plug is shorted
  task automatic t_hold;
    repeat (30 * TK) @(negedge clk);
    chk("open after glitch", 8'h7, 8'({ls, jt, ev}));
    read_ev();
    active_low_shutdown_n = 0;
    en = 0;
    plug = 2'h1;
    repeat (40 * TK) @(negedge clk);
    chk("flags held", 8'h6, 8'({ls, jt, ev}));
    chk("detect outputs off", 8'h0, 8'({cen, spu, wpu}));
  endtask
  initial begin
    repeat (16) @(negedge clk);
    chk("reset outputs", 8'h0, 8'({cen, spu, wpu, ls, jt, ev, irq, rsel}));
    rst = 0;
    t_config();
    t_deb(2'h0, 2'h0, 2'h3);
    t_deb(2'h1, 2'h1, 2'h0);
    t_deb(2'h2, 2'h2, 2'h1);
    t_deb(2'h3, 2'h0, 2'h3);
    msk = 1;
    t_deb(2'h0, 2'h2, 2'h1);
    msk = 0;
    wk = 1;
    t_deb(2'h0, 2'h2, 2'h0);
    wk = 0;
    t_sticky();
    t_glitch();
    t_hold();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
